// ### motion_core_model.sv
/* Behavioural motion core facing the command block.
   Assumes one clock; finishes every move and home after fixed delays. */
`timescale 1ns/1ps
module motion_core_model (
	input  wire clock_i,
	input  wire rst_n_i,
	input  wire start_move_i,
	input  wire start_home_i,
	input  wire push_mode_i,
	input  wire servo_enable_i,
	input  wire alarm_req_i,
	input  wire hit_i,
	input  wire warn_sys_i,
	input  wire warn_enc_i,
	output reg  ready_o,
	output reg  servo_on_o,
	output reg  move_done_o,
	output reg  home_done_o,
	output reg  push_ok_o,
	output reg  push_miss_o,
	output reg  alarm_o,
	output reg  sys_warn_o,
	output reg  enc_warn_o
);
reg [7:0] mcnt;
reg [7:0] hcnt;
reg [3:0] drive_enable_in;
reg       push_q;
// Servo lags its enable so the status pin cannot merely echo the command.
always @(posedge clock_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		{ready_o, servo_on_o, move_done_o, home_done_o, push_ok_o, push_miss_o} <= 6'h00;
		{alarm_o, sys_warn_o, enc_warn_o, push_q, drive_enable_in, mcnt, hcnt} <= 24'h000000;
	end else begin
		ready_o <= 1'b1;
		drive_enable_in <= {drive_enable_in[2:0], servo_enable_i};
		servo_on_o <= drive_enable_in[3];
		mcnt <= start_move_i ? 8'h14 : mcnt - {7'h00, |mcnt};
		hcnt <= start_home_i ? 8'h14 : hcnt - {7'h00, |hcnt};
		if (start_move_i)
			push_q <= push_mode_i;
		move_done_o <= mcnt == 8'h01;
		home_done_o <= hcnt == 8'h01;
		push_ok_o <= mcnt == 8'h01 && push_q && hit_i;
		push_miss_o <= mcnt == 8'h01 && push_q && !hit_i;
		{alarm_o, sys_warn_o, enc_warn_o} <= {alarm_req_i, warn_sys_i, warn_enc_i};
	end
end
endmodule // motion_core_model

// ### positioner_consts.vh
/*
 * Constants for the standard-mode parallel I/O command block: register
 * offsets, field positions, reset values and timing figures.
 * Assumes it is included by its bare name from the design file.
 */
`ifndef POSITIONER_CONSTS_VH
`define POSITIONER_CONSTS_VH

// ********************************************************************
// Register offsets on the plain register port.
// ********************************************************************
`define REG_CONFIG        4'h0
`define REG_STATUS        4'h4
`define REG_INDEX         4'h8

// ********************************************************************
// Configuration register fields and reset values.
// ********************************************************************
`define CFG_MODE_LSB      0
`define CFG_MODE_MSB      7
`define CFG_ENC_LSB       8
`define CFG_ENC_MSB       15
`define CFG_TWO_AXIS_BIT  16
`define MODE_STANDARD     8'h01
`define MODE_RESET        8'h01
`define ENC_RESET         8'h00
`define ENC_BINARY        8'h00

// ********************************************************************
// Status register bit positions.
// ********************************************************************
`define ST_FAULT_N        0
`define ST_READY          1
`define ST_IN_POS         2
`define ST_HOME_DONE      3
`define ST_DRIVE_ON       4
`define ST_PRESS_DONE     5
`define ST_SYS_BATT       6
`define ST_ENC_BATT       7
`define ST_ALARM          8
`define ST_HOME_ERR       9
`define ST_INDEX_ERR      10
`define ST_ACTIVE         11

// ********************************************************************
// Index limits and widths.
// ********************************************************************
`define INDEX_PINS        13
`define INDEX_W           11
`define INDEX_MAX         11'h5dc

// ********************************************************************
// Timing: least index setup before the trigger, in ns, and cycles.
// ********************************************************************
`define CLK_PERIOD_NS     5
`define INDEX_SETUP_NS    6000000
`define INDEX_SETUP_CYC   ((`INDEX_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### positioner_standard_pio.v
/*
 * Standard-mode parallel I/O command block of an actuator positioner.
 * It synchronises the discrete host inputs, detects their edges, decodes
 * the target index and issues command pulses to the motion core; it
 * drives the status pins from motion-core events.
 * Assumes the motion core and the register master run on clock_i; the
 * discrete host inputs are asynchronous to it.
 * The motion core, the position table and the servo loop live outside
 * this file and meet it only through the core ports.
 */
`timescale 1ns/1ps
`include "positioner_consts.vh"

module positioner_standard_pio (
	input  wire        clock_i,
	input  wire        rst_n_i,
	input  wire        move_trigger_i,
	input  wire        homing_i,
	input  wire        drive_enable_in_i,
	input  wire        push_i,
	input  wire        hold_n_i,
	input  wire        abort_n_i,
	input  wire        interpolation_i,
	input  wire        fault_clear_i,
	input  wire [12:0] target_index_i,
	input  wire        core_ready_i,
	input  wire        servo_on_i,
	input  wire        move_done_i,
	input  wire        in_band_i,
	input  wire        home_done_i,
	input  wire        push_ok_i,
	input  wire        push_miss_i,
	input  wire        alarm_event_i,
	input  wire        sys_batt_warn_i,
	input  wire        enc_batt_warn_i,
	input  wire [3:0]  reg_addr_i,
	input  wire [31:0] reg_wdata_i,
	input  wire        reg_wr_i,
	input  wire        reg_rd_i,
	output reg  [31:0] reg_rdata_o,
	output reg         fault_n_o,
	output reg         controller_ready_o,
	output reg         in_position_done_o,
	output reg         homing_done_o,
	output reg         drive_on_out_o,
	output reg         press_done_o,
	output reg         sysmem_batt_low_o,
	output reg         encoder_batt_low_o,
	output reg         start_move_o,
	output reg         start_home_o,
	output reg         push_mode_o,
	output reg         interp_mode_o,
	output reg  [10:0] move_index_o,
	output reg         servo_enable_o,
	output reg         decel_stop_o,
	output reg         cancel_travel_o,
	output reg         alarm_clear_o
);

	// ****************************************************************
	// Input synchronisers.
	// ****************************************************************
	localparam NSYNC = 21;

	wire [NSYNC-1:0] raw_in;
	reg  [NSYNC-1:0] sync_a;
	reg  [NSYNC-1:0] sync_b;
	reg  [NSYNC-1:0] sync_prev;

	// Packed pin order, low bit first: 0 trigger, 1 homing, 2 drive enable,
	// 3 push, 4 hold_n, 5 abort_n, 6 interpolation, 7 fault clear and
	// 8 to 20 the index pins. The picks below depend on this order.
	assign raw_in = {target_index_i, fault_clear_i, interpolation_i, abort_n_i,
	                 hold_n_i, push_i, drive_enable_in_i, homing_i, move_trigger_i};

	// Two synchroniser flops per pin plus sync_prev; the logic below reads only sync_b and sync_prev.
	// The two active-low pins reset to their idle high level, so the
	// release of reset shows neither a pause nor a cancel edge.
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
			always @(posedge clock_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					sync_a[gi]    <= (gi == 4 || gi == 5) ? 1'b1 : 1'b0;
					sync_b[gi]    <= (gi == 4 || gi == 5) ? 1'b1 : 1'b0;
					sync_prev[gi] <= (gi == 4 || gi == 5) ? 1'b1 : 1'b0;
				end else begin
					sync_a[gi]    <= raw_in[gi];
					sync_b[gi]    <= sync_a[gi];
					sync_prev[gi] <= sync_b[gi];
				end
			end
		end
	endgenerate

	// Synchronised levels, named for the logic that reads them.
	wire        trig_s  = sync_b[0];
	wire        drv_s   = sync_b[2];
	wire        push_s  = sync_b[3];
	wire        hold_s  = sync_b[4];
	wire        abort_s = sync_b[5];
	wire        line_s  = sync_b[6];
	wire [12:0] idx_s   = sync_b[20:8];

	// Rising edge of one synchronised pin from two successive samples.
	// A falling edge is the rising edge of the inverted pair.
	function rising;
		input now_v;
		input was_v;
		begin
			rising = now_v & ~was_v;
		end
	endfunction

	// Edges come from successive synchronised samples, never from the raw
	// pins, so every edge lasts exactly one clock cycle and no pin change
	// between two clock edges can be caught half-way.
	wire trig_rise  = rising(sync_b[0], sync_prev[0]);
	wire home_rise  = rising(sync_b[1], sync_prev[1]);
	wire abort_fall = rising(~sync_b[5], ~sync_prev[5]);
	wire clear_rise = rising(sync_b[7], sync_prev[7]);

	// ****************************************************************
	// Index decoding.
	// ****************************************************************
	// Binary: pin k weighs 2^(k-1), but pin 13 weighs 2^11. BCD: four digit groups, top pin is
	// the thousands digit. Digits above nine are not trapped here; the
	// range check below catches the results that would overflow.
	// The tens digit is built as eight times plus two times the digit, which
	// keeps that term to shifts and adds.
	function [11:0] decode_index;
		input [12:0] pins;
		input        bcd;
		begin
			if (bcd)
				decode_index = {8'h00, pins[3:0]}
				             + {5'h00, pins[7:4], 3'b000} + {7'h00, pins[7:4], 1'b0}
				             + ({8'h00, pins[11:8]} * 12'd100)
				             + (pins[12] ? 12'd1000 : 12'd0);
			else
				decode_index = {1'b0, pins[10:0]}
				             | (pins[12:11] != 2'b00 ? 12'h800 : 12'h000);
		end
	endfunction

	// ****************************************************************
	// Configuration register.
	// ****************************************************************
	// Configuration setting: operation mode, index encoding, two axes.
	reg  [7:0] cfg_mode;
	reg  [7:0] cfg_enc;
	reg        cfg_two_axis;

	// The pattern only acts in standard mode; any other mode value parks
	// every command and level control while the status pins still update.
	wire active  = (cfg_mode == `MODE_STANDARD);
	wire use_bcd = (cfg_enc != `ENC_BINARY);

	// Index as a number, and whether it lies beyond the top position.
	wire [11:0] idx_value = decode_index(idx_s, use_bcd);
	wire        idx_bad   = (idx_value > {1'b0, `INDEX_MAX});

	// Register address match, shared by the write and read paths so the
	// two sides of the port cannot disagree on the map.
	function addr_is;
		input [3:0] addr;
		input [3:0] offset;
		begin
			addr_is = (addr == offset);
		end
	endfunction

	wire sel_config = addr_is(reg_addr_i, `REG_CONFIG);
	wire sel_status = addr_is(reg_addr_i, `REG_STATUS);
	wire sel_index  = addr_is(reg_addr_i, `REG_INDEX);

	// Only the configuration word is writable; writes elsewhere vanish.
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_mode     <= `MODE_RESET;
			cfg_enc      <= `ENC_RESET;
			cfg_two_axis <= 1'b0;
		end else if (reg_wr_i && sel_config) begin
			cfg_mode     <= reg_wdata_i[`CFG_MODE_MSB:`CFG_MODE_LSB];
			cfg_enc      <= reg_wdata_i[`CFG_ENC_MSB:`CFG_ENC_LSB];
			cfg_two_axis <= reg_wdata_i[`CFG_TWO_AXIS_BIT];
		end
	end

	// ****************************************************************
	// Command acceptance.
	// ****************************************************************
	// Move and home commands are only taken while the pattern is active and the drive
	// is enabled; otherwise they vanish silently, with no error.
	// A command lost that way is not replayed when the drive comes back;
	// the host must raise the pin again.
	wire cmd_ok     = active & drv_s;
	wire take_move  = cmd_ok & trig_rise;
	wire take_home  = cmd_ok & home_rise;
	wire home_miss  = take_move & ~homing_done_o;
	wire range_miss = take_move & homing_done_o & idx_bad;
	wire go_move    = take_move & homing_done_o & ~idx_bad;
	wire clear_ok   = active & clear_rise;

	// Latched error flags behind the fault pin and the status word.
	reg alarm;
	reg home_err;
	reg index_err;

	// Alarm flags: a new event in the clear cycle wins over the clear.
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			alarm     <= 1'b0;
			home_err  <= 1'b0;
			index_err <= 1'b0;
		end else begin
			alarm     <= alarm_event_i | home_miss | range_miss
			           | (alarm & ~clear_ok);
			home_err  <= home_miss | (home_err & ~clear_ok);
			index_err <= range_miss | (index_err & ~clear_ok);
		end
	end

	// Command pulses and mode qualifiers to the motion core.
	// The qualifiers are held until the next accepted move, so the core
	// may read them at any time during travel.
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			start_move_o    <= 1'b0;
			start_home_o    <= 1'b0;
			push_mode_o     <= 1'b0;
			interp_mode_o   <= 1'b0;
			move_index_o    <= 11'h000;
			cancel_travel_o <= 1'b0;
			alarm_clear_o   <= 1'b0;
		end else begin
			start_move_o    <= go_move;
			start_home_o    <= take_home;
			cancel_travel_o <= active & abort_fall;
			alarm_clear_o   <= clear_ok;
			if (go_move) begin
				move_index_o  <= idx_value[10:0];
				push_mode_o   <= push_s;
				interp_mode_o <= line_s & cfg_two_axis;
			end
		end
	end

	// Level controls: servo enable and pause. The index setup time is
	// the host's job; the block samples the index on the trigger edge.
	// Pause and cancel both stop the axis; only cancel also drops the
	// remaining travel, through its own pulse.
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			servo_enable_o <= 1'b0;
			decel_stop_o   <= 1'b0;
		end else begin
			servo_enable_o <= active & drv_s;
			decel_stop_o   <= active & (~hold_s | ~abort_s);
		end
	end

	// ****************************************************************
	// Status outputs.
	// ****************************************************************
	// Core levels and the inverted alarm flag, one cycle late so that each pin comes
	// straight from a flop.
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fault_n_o          <= 1'b1;
			controller_ready_o <= 1'b0;
			drive_on_out_o     <= 1'b0;
			sysmem_batt_low_o  <= 1'b0;
			encoder_batt_low_o <= 1'b0;
		end else begin
			fault_n_o          <= ~alarm;
			controller_ready_o <= core_ready_i;
			drive_on_out_o     <= servo_on_i;
			sysmem_batt_low_o  <= sys_batt_warn_i;
			encoder_batt_low_o <= enc_batt_warn_i;
		end
	end

	// Positioning complete drops on a new move and sets only once the
	// trigger is released and the core reports the deviation in band.
	// A paused or de-energised axis cannot set complete; a set flag holds until the next move.
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			in_position_done_o <= 1'b0;
		end else if (go_move) begin
			in_position_done_o <= 1'b0;
		end else if (move_done_i && in_band_i && !trig_s && hold_s && servo_on_i) begin
			in_position_done_o <= 1'b1;
		end
	end

	// Home done clears on a new home command, so a failed re-home does
	// not leave a stale completion showing; a completion in the same
	// cycle as a new command wins.
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			homing_done_o <= 1'b0;
		end else if (home_done_i) begin
			homing_done_o <= 1'b1;
		end else if (take_home) begin
			homing_done_o <= 1'b0;
		end
	end

	// Press done sets on a successful push and drops on a miss or on the
	// start of the next move, so it always belongs to the latest push.
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			press_done_o <= 1'b0;
		end else if (push_ok_i) begin
			press_done_o <= 1'b1;
		end else if (push_miss_i || go_move) begin
			press_done_o <= 1'b0;
		end
	end

	// ****************************************************************
	// Register read port.
	// ****************************************************************
	// Status word: the pins as driven, then the latched error flags, then the active bit.
	wire [31:0] status_word = {20'h00000, active, index_err, home_err, alarm,
	                           encoder_batt_low_o, sysmem_batt_low_o, press_done_o,
	                           drive_on_out_o, homing_done_o, in_position_done_o,
	                           controller_ready_o, fault_n_o};

	// Read data stand in the cycle after the strobe only; zero otherwise.
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 32'h00000000;
		end else if (reg_rd_i) begin
			if (sel_config)
				reg_rdata_o <= {15'h0000, cfg_two_axis, cfg_enc, cfg_mode};
			else if (sel_status)
				reg_rdata_o <= status_word;
			else if (sel_index)
				reg_rdata_o <= {21'h000000, move_index_o};
			else
				reg_rdata_o <= 32'h00000000;
		end else begin
			reg_rdata_o <= 32'h00000000;
		end
	end

endmodule // positioner_standard_pio

// ### positioner_standard_pio_checker.sv
/* Concurrent checks on the parallel I/O command block.
   Assumes it is bound to the design top and sees its ports only. */
`timescale 1ns/1ps
`include "positioner_consts.vh"
module positioner_standard_pio_checker (
	input wire        clock_i,
	input wire        rst_n_i,
	input wire        move_trigger_i,
	input wire        homing_i,
	input wire        drive_enable_in_i,
	input wire        core_ready_i,
	input wire        servo_on_i,
	input wire        move_done_i,
	input wire        in_band_i,
	input wire        home_done_i,
	input wire        push_ok_i,
	input wire        alarm_event_i,
	input wire        reg_rd_i,
	input wire [31:0] reg_rdata_o,
	input wire        fault_n_o,
	input wire        controller_ready_o,
	input wire        in_position_done_o,
	input wire        homing_done_o,
	input wire        drive_on_out_o,
	input wire        press_done_o,
	input wire        start_move_o,
	input wire        start_home_o,
	input wire [10:0] move_index_o
);
// ****
// Checks
// ****
default clocking @(posedge clock_i); endclocking
default disable iff (!rst_n_i);
// A start is one cycle long, so a held pin never restarts the move.
sequence move_go;
	start_move_o ##1 !start_move_o;
endsequence
a_move_pulse: assert property (start_move_o |-> move_go) else $error("move start not one cycle");
a_move_cause: assert property (start_move_o |-> $past(move_trigger_i, 2) && $past(drive_enable_in_i, 2)
	&& homing_done_o) else $error("move start without cause");
a_home_cause: assert property (start_home_o |-> $past(homing_i, 2) && $past(drive_enable_in_i, 2))
	else $error("home start without cause");
a_index_range: assert property (start_move_o |-> move_index_o <= `INDEX_MAX) else $error("index out of range");
a_fault_set: assert property (alarm_event_i |-> ##2 !fault_n_o) else $error("alarm not shown");
a_ready_lag: assert property (1'b1 |=> controller_ready_o == $past(core_ready_i)) else $error("ready lag");
a_servo_lag: assert property (1'b1 |=> drive_on_out_o == $past(servo_on_i)) else $error("servo lag");
a_home_set: assert property (home_done_i |=> homing_done_o) else $error("home done not set");
a_home_cause2: assert property ($rose(homing_done_o) |-> $past(home_done_i)) else $error("home done early");
a_pos_set: assert property ($rose(in_position_done_o) |-> $past(move_done_i) && $past(in_band_i)
	&& $past(servo_on_i)) else $error("in position early");
a_press_set: assert property (push_ok_i |=> press_done_o) else $error("press done not set");
a_rd_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0) else $error("read data not idle");
endmodule // positioner_standard_pio_checker
bind positioner_standard_pio positioner_standard_pio_checker i_chk (.*);

// ### positioner_standard_pio_tb.sv
/* Self-checking bench for the parallel I/O command block.
   Assumes the motion core model on the far side and a 200 MHz clock. */
`timescale 1ns/1ps
`include "positioner_consts.vh"
module positioner_standard_pio_tb;
reg clock_i = 0, rst_n_i = 0, move_trigger_i = 0, homing_i = 0, drive_enable_in_i = 0, push_i = 0;
reg hold_n_i = 1, abort_n_i = 1, interpolation_i = 0, fault_clear_i = 0, reg_wr_i = 0, reg_rd_i = 0;
reg [12:0] target_index_i = 0;
reg [3:0] reg_addr_i = 0;
reg [31:0] reg_wdata_i = 0;
reg alarm_req = 0, hit = 1, warn_s = 0, warn_e = 0;
integer err_count = 0, n_checks = 0;
wire core_ready_i, servo_on_i, move_done_i, home_done_i, push_ok_i, push_miss_i, alarm_event_i;
wire sys_batt_warn_i, enc_batt_warn_i, fault_n_o, controller_ready_o, in_position_done_o, homing_done_o;
wire drive_on_out_o, press_done_o, sysmem_batt_low_o, encoder_batt_low_o, start_move_o, start_home_o;
wire push_mode_o, interp_mode_o, servo_enable_o, decel_stop_o, cancel_travel_o, alarm_clear_o;
wire [10:0] move_index_o;
wire [31:0] reg_rdata_o;
wire in_band_i = servo_on_i;
always #2.5 clock_i = !clock_i;
positioner_standard_pio i_dut (.*);
motion_core_model i_core (.clock_i(clock_i), .rst_n_i(rst_n_i), .start_move_i(start_move_o),
	.start_home_i(start_home_o), .push_mode_i(push_mode_o), .servo_enable_i(servo_enable_o),
	.alarm_req_i(alarm_req), .hit_i(hit), .warn_sys_i(warn_s), .warn_enc_i(warn_e), .ready_o(core_ready_i),
	.servo_on_o(servo_on_i), .move_done_o(move_done_i), .home_done_o(home_done_i), .push_ok_o(push_ok_i),
	.push_miss_o(push_miss_i), .alarm_o(alarm_event_i), .sys_warn_o(sys_batt_warn_i),
	.enc_warn_o(enc_batt_warn_i));
// ****
// Tasks
// ****
task chk(input string nm, input [31:0] e, input [31:0] g);
begin
	n_checks = n_checks + 1;
	if (g !== e) begin
		err_count = err_count + 1;
		$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
	end
end
endtask
task cyc(input integer n);
	repeat (n) @(posedge clock_i);
endtask
task wr(input [3:0] a, input [31:0] d);
begin
	reg_addr_i <= a;
	reg_wdata_i <= d;
	reg_wr_i <= 1'b1;
	cyc(1);
	reg_wr_i <= 1'b0;
end
endtask
// Read data stand one cycle only, so they are taken mid-cycle after the strobe.
task rd(input [3:0] a, input [31:0] e);
begin
	reg_addr_i <= a;
	reg_rd_i <= 1'b1;
	cyc(1);
	reg_rd_i <= 1'b0;
	@(negedge clock_i);
	chk("read data", e, reg_rdata_o);
	cyc(1);
end
endtask
// Watch a one-cycle pulse over a bounded window: move, home, cancel, clear.
task wait_go(input [1:0] sel, output reg seen);
integer i;
reg g;
begin
	seen = 1'b0;
	for (i = 0; i < 8; i = i + 1) begin
		@(negedge clock_i);
		g = (sel == 0) ? start_move_o : (sel == 1) ? start_home_o : (sel == 2) ? cancel_travel_o : alarm_clear_o;
		if (g === 1'b1)
			seen = 1'b1;
	end
	cyc(1);
end
endtask
task move(input [12:0] idx, input p, input ip, input go, input [10:0] e);
reg seen;
begin
	target_index_i <= idx;
	push_i <= p;
	interpolation_i <= ip;
	cyc(4); // Index settles ahead of the trigger
	move_trigger_i <= 1'b1;
	wait_go(0, seen);
	chk("start_move", go, seen);
	if (go) begin
		chk("move_index", e, move_index_o);
		chk("push_mode", p, push_mode_o);
		chk("interp_mode", ip, interp_mode_o);
	end
	move_trigger_i <= 1'b0;
	cyc(40);
	if (go)
		chk("in_position", 1, in_position_done_o);
end
endtask
task home(input go);
reg seen;
begin
	homing_i <= 1'b1;
	wait_go(1, seen);
	chk("start_home", go, seen);
	homing_i <= 1'b0;
	cyc(40);
	chk("homing_done", go, homing_done_o);
end
endtask
task clr;
reg seen;
begin
	chk("fault_n", 0, fault_n_o);
	fault_clear_i <= 1'b1;
	wait_go(3, seen);
	chk("alarm_clear", 1, seen);
	fault_clear_i <= 1'b0;
	cyc(3);
	chk("fault_n", 1, fault_n_o);
end
endtask
task test_done;
begin
	$display("checks %0d mismatches %0d", n_checks, err_count);
	if (err_count == 0 && n_checks > 0)
		$display("All tests passed");
	else
		$display("Some tests failed");
	$finish;
end
endtask
// ****
// Main sequence
// ****
integer k;
reg s;
initial begin
	cyc(2);
	rst_n_i <= 1'b1;
	cyc(12);
	chk("fault_n", 1, fault_n_o);
	chk("ready", 1, controller_ready_o);
	rd(`REG_CONFIG, 32'h0000_0001);
	rd(4'hc, 32'h0);
	home(0);
	drive_enable_in_i <= 1'b1;
	cyc(12);
	chk("servo_enable", 1, servo_enable_o);
	chk("drive_on", 1, drive_on_out_o);
	move(13'h0005, 0, 0, 0, 0);
	rd(`REG_STATUS, 32'h0000_0b12);
	clr;
	home(1);
	for (k = 0; k < 11; k = k + 1)
		move(13'h0001 << k, 0, 0, 1, 11'h001 << k);
	move(13'h05dc, 0, 0, 1, 11'h5dc);
	move(13'h05dd, 0, 0, 0, 0);
	rd(`REG_STATUS, 32'h0000_0d1e);
	clr;
	wr(`REG_CONFIG, 32'h0001_0101);
	rd(`REG_CONFIG, 32'h0001_0101);
	move(13'h1234, 1, 1, 1, 11'h4d2);
	rd(`REG_INDEX, 32'h0000_04d2);
	chk("press_done", 1, press_done_o);
	hit <= 1'b0;
	move(13'h0001, 1, 0, 1, 11'h001);
	chk("press_done", 0, press_done_o);
	hold_n_i <= 1'b0;
	cyc(5);
	chk("decel_stop", 1, decel_stop_o);
	hold_n_i <= 1'b1;
	abort_n_i <= 1'b0;
	wait_go(2, s);
	chk("cancel_travel", 1, s);
	abort_n_i <= 1'b1;
	{warn_s, warn_e, alarm_req} <= 3'b111;
	cyc(1);
	alarm_req <= 1'b0;
	cyc(4);
	chk("sys_batt", 1, sysmem_batt_low_o);
	chk("enc_batt", 1, encoder_batt_low_o);
	clr;
	wr(`REG_CONFIG, 32'h0000_0002);
	move(13'h0003, 0, 0, 0, 0);
	test_done;
end
endmodule // positioner_standard_pio_tb
